// ==== logic/cmd_reporter.sv ====
// Command checker: picks one error or warning per line, times mastering
`timescale 1ns/1ps
`include "cmd_report_defines.svh"

module cmd_reporter #(
	parameter int unsigned MASTER_WAIT_CYC =
		`MASTER_TIMEOUT_MS * `CLK_PER_MS
) (
	input wire logic REF_CLK_I,
	input wire logic RSTN_I,
	input wire logic RX_VALID_I,
	input wire logic [7:0] RX_BYTE_I,
	input wire cmd_report_pkg::cmd_check_s CHECK_I,
	input wire cmd_report_pkg::dev_state_s STATE_I,
	input wire logic [`ROI_W-1:0] ROI_START_I,
	input wire logic [`ROI_W-1:0] ROI_END_I,
	input wire logic OUT_WRITE_FAIL_I,
	input wire cmd_report_pkg::upd_evt_s UPD_EVT_I,
	input wire logic MEAS_VALID_I,
	output logic REPORT_VALID_O,
	output cmd_report_pkg::report_s REPORT_O,
	output logic EXEC_O,
	output logic MASTER_TAKE_O,
	output logic MASTER_BUSY_O
);
	import cmd_report_pkg::*;

	localparam int unsigned TMR_W = $clog2(MASTER_WAIT_CYC + 1);
	localparam int unsigned P_IO = 0;
	localparam int unsigned P_TMO = 1;

	logic line_done;
	logic line_bad;
	logic line_long;
	logic [`PEND_N-1:0] pend_q;
	logic [`PEND_N-1:0] pend_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	mstate_e mstate_q;
	mstate_e mstate_d;
	logic rep_valid_q;
	report_s rep_q;
	logic exec_q;
	logic take_q;
	logic busy_q;

	line_scanner #(
		.MAX_LEN(`LINE_MAX),
		.LEN_W(`LEN_W)
	) u_scan (
		.clk_i(REF_CLK_I),
		.rstn_i(RSTN_I),
		.valid_i(RX_VALID_I),
		.byte_i(RX_BYTE_I),
		.done_o(line_done),
		.bad_o(line_bad),
		.long_o(line_long)
	);

	// Command checks, listed in reporting priority
	wire f_char = line_bad;
	wire f_long = line_long;
	wire f_name = !CHECK_I.known || !CHECK_I.permitted;
	wire f_expert = CHECK_I.needs_expert && !STATE_I.expert;
	wire f_count = !CHECK_I.count_ok;
	wire f_type = !CHECK_I.type_ok;
	wire f_range = !CHECK_I.range_ok;
	wire f_busy = CHECK_I.needs_stop && STATE_I.stream_active;
	// Equal bounds are left to the host, only reversed order is caught
	wire f_roi = CHECK_I.is_roi && (ROI_START_I > ROI_END_I);
	wire f_mv = CHECK_I.is_master && !CHECK_I.master_ok;
	wire f_trig = CHECK_I.is_swtrig && !STATE_I.swtrig_mode;
	wire f_full = CHECK_I.is_save && STATE_I.store_full;
	wire f_blank = CHECK_I.is_save && CHECK_I.name_blank;
	wire f_dup = CHECK_I.is_save && CHECK_I.name_bad;
	wire f_miss = CHECK_I.is_load && !CHECK_I.name_found;
	wire f_inval = CHECK_I.is_load && !CHECK_I.setting_ok;

	wire any_err = f_char || f_long || f_name || f_expert || f_count ||
		f_type || f_range || f_busy || f_roi || f_mv || f_trig ||
		f_full || f_blank || f_dup || f_miss || f_inval;

	// First failing check wins so only one code goes out
	wire [`CODE_W-1:0] err_code =
		f_char ? `E_BAD_CHAR :
		f_long ? `E_TOO_LONG :
		f_name ? `E_UNKNOWN :
		f_expert ? `E_ACCESS :
		f_count ? `E_PAR_COUNT :
		f_type ? `E_PAR_TYPE :
		f_range ? `E_PAR_RANGE :
		f_busy ? `E_STREAM_ON :
		f_roi ? `E_ROI_ORDER :
		f_mv ? `E_MV_RANGE :
		f_trig ? `E_SWTRIG_OFF :
		f_full ? `E_STORE_FULL :
		f_blank ? `E_NAME_BLANK :
		f_dup ? `E_NAME_BAD :
		f_miss ? `E_NAME_MISSING :
		`E_SET_INVALID;

	wire any_warn = CHECK_I.clipped || CHECK_I.out_changed;
	wire [`CODE_W-1:0] warn_code =
		CHECK_I.clipped ? `W_CLIPPED : `W_OUT_ADAPTED;

	wire cmd_ok = line_done && !any_err;
	wire cmd_rep = line_done && (any_err || any_warn);
	wire master_go = cmd_ok && CHECK_I.is_master;

	// Mastering wait for the next measurement value
	wire in_wait = mstate_q == M_WAIT;
	wire meas_take = in_wait && MEAS_VALID_I;
	wire tmr_end = tmr_q == TMR_W'(MASTER_WAIT_CYC - 1);
	wire tmo_evt = in_wait && tmr_end && !MEAS_VALID_I;

	always_comb
	begin
		mstate_d = mstate_q;
		tmr_d = tmr_q;
		unique case (mstate_q)
			M_IDLE:
			begin
				tmr_d = '0;
				if (master_go)
					mstate_d = M_WAIT;
			end
			M_WAIT:
			begin
				tmr_d = tmr_q + 1'b1;
				if (master_go)
					tmr_d = '0;
				else if (meas_take || tmr_end)
				begin
					mstate_d = M_IDLE;
					tmr_d = '0;
				end
			end
			default:
			begin
				mstate_d = M_IDLE;
				tmr_d = '0;
			end
		endcase
	end

	// Events outside a command line wait here until the report slot frees
	wire [`PEND_N-1:0] pend_set = {UPD_EVT_I.xfer_tmo, UPD_EVT_I.xfer_err,
		UPD_EVT_I.too_large, UPD_EVT_I.bad_header,
		tmo_evt, OUT_WRITE_FAIL_I};
	wire serve = !cmd_rep && (pend_q != '0);
	wire [`PEND_N-1:0] pick = pend_q & (~pend_q + 1'b1);
	wire [`PEND_N-1:0] pend_clr = serve ? pick : '0;
	// Set wins over clear for an event in the serving cycle
	assign pend_d = (pend_q & ~pend_clr) | pend_set;

	wire [`CODE_W-1:0] pend_code =
		pick[P_IO] ? `E_IO_FAIL :
		pick[P_TMO] ? `E_MASTER_TMO :
		pick[2] ? `E_UPD_HEADER :
		pick[3] ? `E_UPD_SIZE :
		pick[4] ? `E_UPD_XFER :
		`E_UPD_TMO;

	wire [`CODE_W-1:0] rep_code =
		cmd_rep ? (any_err ? err_code : warn_code) : pend_code;
	wire rep_warn = cmd_rep && !any_err;

	always_ff @(posedge REF_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			mstate_q <= M_IDLE;
			tmr_q <= '0;
			pend_q <= '0;
			rep_valid_q <= 1'b0;
			rep_q <= '0;
			exec_q <= 1'b0;
			take_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			mstate_q <= mstate_d;
			tmr_q <= tmr_d;
			pend_q <= pend_d;
			rep_valid_q <= cmd_rep || serve;
			// Last report stays readable until the next one replaces it
			if (cmd_rep || serve)
				rep_q <= report_s'{rep_warn, rep_code};
			exec_q <= cmd_ok;
			take_q <= meas_take;
			busy_q <= mstate_d == M_WAIT;
		end
	end

	assign REPORT_VALID_O = rep_valid_q;
	assign REPORT_O = rep_q;
	assign EXEC_O = exec_q;
	assign MASTER_TAKE_O = take_q;
	assign MASTER_BUSY_O = busy_q;

	property p_no_exec_err;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		line_done && any_err |=> !EXEC_O && REPORT_VALID_O && !REPORT_O.warn;
	endproperty
	a_no_exec_err: assert property (p_no_exec_err)
		else $error("Rejected command executed or unreported");

	property p_bad_char;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		line_done && line_bad |=> REPORT_O.code == `E_BAD_CHAR;
	endproperty
	a_bad_char: assert property (p_bad_char)
		else $error("Bad character not reported");

	property p_too_long;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		line_done && line_long && !line_bad |=>
			REPORT_O.code == `E_TOO_LONG;
	endproperty
	a_too_long: assert property (p_too_long)
		else $error("Long line not reported");

	property p_unknown;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		line_done && !line_bad && !line_long && !CHECK_I.known |=>
			REPORT_VALID_O && REPORT_O.code == `E_UNKNOWN;
	endproperty
	a_unknown: assert property (p_unknown)
		else $error("Unknown command not reported");

	property p_expert;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		line_done && !line_bad && !line_long && !f_name &&
			CHECK_I.needs_expert && !STATE_I.expert |=>
			REPORT_O.code == `E_ACCESS && !EXEC_O;
	endproperty
	a_expert: assert property (p_expert)
		else $error("Missing expert login not reported");

	property p_warn_clip;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		line_done && !any_err && CHECK_I.clipped |=>
			EXEC_O && REPORT_O.warn && REPORT_O.code == `W_CLIPPED;
	endproperty
	a_warn_clip: assert property (p_warn_clip)
		else $error("Clipped value warning missing");

	property p_tmo_pend;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		in_wait && tmr_end && !MEAS_VALID_I && !master_go |=>
			pend_q[P_TMO] && !MASTER_BUSY_O;
	endproperty
	a_tmo_pend: assert property (p_tmo_pend)
		else $error("Mastering timeout not recorded");

	property p_tmo_bound;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		in_wait |-> tmr_q < TMR_W'(MASTER_WAIT_CYC);
	endproperty
	a_tmo_bound: assert property (p_tmo_bound)
		else $error("Mastering wait ran past its limit");

	property p_io_fail;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		OUT_WRITE_FAIL_I |=> pend_q[P_IO];
	endproperty
	a_io_fail: assert property (p_io_fail)
		else $error("Output write failure lost");

	property p_pend_out;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		!cmd_rep && pend_q[P_IO] |=>
			REPORT_VALID_O && REPORT_O.code == `E_IO_FAIL && !REPORT_O.warn;
	endproperty
	a_pend_out: assert property (p_pend_out)
		else $error("Pending write failure not reported");

	property p_roi;
		@(posedge REF_CLK_I) disable iff (!RSTN_I)
		line_done && !(f_char || f_long || f_name || f_expert || f_count ||
			f_type || f_range || f_busy) && CHECK_I.is_roi &&
			ROI_START_I > ROI_END_I |=> REPORT_O.code == `E_ROI_ORDER;
	endproperty
	a_roi: assert property (p_roi)
		else $error("Reversed region not reported");

endmodule

// ==== logic/line_scanner.sv ====
// Byte stream scanner: line length and character set per command line
`timescale 1ns/1ps
`include "cmd_report_defines.svh"

module line_scanner #(
	parameter int unsigned MAX_LEN = `LINE_MAX,
	parameter int unsigned LEN_W = `LEN_W
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic valid_i,
	input wire logic [7:0] byte_i,
	output logic done_o,
	output logic bad_o,
	output logic long_o
);

	logic [LEN_W-1:0] cnt_q;
	logic [LEN_W-1:0] cnt_d;
	logic bad_acc_q;
	logic done_q;
	logic bad_q;
	logic long_q;

	wire is_term = (byte_i == `CH_CR) || (byte_i == `CH_LF);
	wire is_bad = !is_term && ((byte_i < `CH_LO) || (byte_i > `CH_HI));
	// Saturate one past the limit so very long lines stay flagged
	wire at_top = cnt_q == LEN_W'(MAX_LEN + 1);
	assign cnt_d = is_term ? '0 : (at_top ? cnt_q : cnt_q + 1'b1);

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_q <= '0;
			bad_acc_q <= 1'b0;
			done_q <= 1'b0;
			bad_q <= 1'b0;
			long_q <= 1'b0;
		end
		else
		begin
			done_q <= valid_i && is_term;
			if (valid_i)
			begin
				cnt_q <= cnt_d;
				bad_acc_q <= !is_term && (bad_acc_q || is_bad);
			end
			if (valid_i && is_term)
			begin
				bad_q <= bad_acc_q;
				long_q <= cnt_q > LEN_W'(MAX_LEN);
			end
		end
	end

	assign done_o = done_q;
	assign bad_o = bad_q;
	assign long_o = long_q;

endmodule

// ==== pkg/cmd_report_defines.svh ====
// Constants for the command error and warning reporter
`ifndef CMD_REPORT_DEFINES_SVH
`define CMD_REPORT_DEFINES_SVH

`define CODE_W 10

// Report numbers, binary value of the decimal code
`define E_IO_FAIL 10'h0C8
`define E_ACCESS 10'h0CA
`define E_BAD_CHAR 10'h0CC
`define E_UNKNOWN 10'h0D2
`define E_TOO_LONG 10'h0D6
`define E_MASTER_TMO 10'h0DC
`define E_PAR_COUNT 10'h0E8
`define E_PAR_TYPE 10'h0EA
`define E_PAR_RANGE 10'h0EC
`define E_STREAM_ON 10'h106
`define E_UPD_HEADER 10'h140
`define E_UPD_SIZE 10'h141
`define E_UPD_XFER 10'h142
`define E_UPD_TMO 10'h143
`define E_NAME_BAD 10'h168
`define E_NAME_BLANK 10'h169
`define E_STORE_FULL 10'h16A
`define E_NAME_MISSING 10'h16B
`define E_SET_INVALID 10'h16C
`define E_ROI_ORDER 10'h258
`define E_MV_RANGE 10'h25A
`define E_SWTRIG_OFF 10'h268
`define W_OUT_ADAPTED 10'h140
`define W_CLIPPED 10'h23A

// Line scanning
`define LINE_MAX 255
`define LEN_W 9
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_LO 8'h20
`define CH_HI 8'h7E

// Mastering wait and region bound width
`define CLK_HZ 40000000
`define MASTER_TIMEOUT_MS 2000
`define CLK_PER_MS (`CLK_HZ / 1000)
`define ROI_W 9

// Pending event slots
`define PEND_N 6

`endif

// ==== pkg/cmd_report_pkg.sv ====
// Types shared by the command error and warning reporter
package cmd_report_pkg;
`include "cmd_report_defines.svh"

	typedef struct packed
	{
		logic known;
		logic permitted;
		logic needs_expert;
		logic count_ok;
		logic type_ok;
		logic range_ok;
		logic needs_stop;
		logic is_roi;
		logic is_master;
		logic master_ok;
		logic is_swtrig;
		logic is_save;
		logic is_load;
		logic name_blank;
		logic name_bad;
		logic name_found;
		logic setting_ok;
		logic clipped;
		logic out_changed;
	} cmd_check_s;

	typedef struct packed
	{
		logic expert;
		logic stream_active;
		logic swtrig_mode;
		logic store_full;
	} dev_state_s;

	typedef struct packed
	{
		logic xfer_tmo;
		logic xfer_err;
		logic too_large;
		logic bad_header;
	} upd_evt_s;

	typedef struct packed
	{
		logic warn;
		logic [`CODE_W-1:0] code;
	} report_s;

	typedef enum logic [1:0]
	{
		M_IDLE = 2'h1,
		M_WAIT = 2'h2
	} mstate_e;

endpackage

// ==== sim/command_error_reporter_bench.sv ====
// Self-checking bench for the command error and warning reporter
`timescale 1ns/1ps
`include "cmd_report_defines.svh"

`define CHK(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("wrong value at %0t: got %h expected %h", \
				$time, got, exp); \
		end \
	end

module command_error_reporter_bench;
	import cmd_report_pkg::*;

	localparam dev_state_s IDLE = 4'b0100;
	localparam logic [13:0] OK_N = 14'h2000;
	logic ref_clk;
	logic rstn;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic [`ROI_W-1:0] roi_s;
	logic [`ROI_W-1:0] roi_e;
	cmd_check_s check;
	dev_state_s st;
	upd_evt_s upd;
	logic wfail;
	logic meas;
	logic rvalid;
	report_s rep;
	logic exec;
	logic take;
	logic busy;
	int errors = 0;
	int num_checks = 0;
	logic [13:0] exp_q[$];
	logic [`CODE_W-1:0] codes [16] = '{`E_BAD_CHAR, `E_TOO_LONG,
		`E_UNKNOWN, `E_UNKNOWN, `E_ACCESS, `E_PAR_COUNT, `E_PAR_TYPE,
		`E_PAR_RANGE, `E_STREAM_ON, `E_MV_RANGE, `E_SWTRIG_OFF,
		`E_STORE_FULL, `E_NAME_BLANK, `E_NAME_BAD, `E_NAME_MISSING,
		`E_SET_INVALID};
	logic [`CODE_W-1:0] evc [5] = '{`E_IO_FAIL, `E_UPD_HEADER,
		`E_UPD_SIZE, `E_UPD_XFER, `E_UPD_TMO};

	host_model i_host_model (
		.clk_i(ref_clk),
		.valid_o(rx_valid),
		.byte_o(rx_byte),
		.roi_start_o(roi_s),
		.roi_end_o(roi_e)
	);

	cmd_reporter #(
		.MASTER_WAIT_CYC(20)
	) i_cmd_reporter (
		.REF_CLK_I(ref_clk),
		.RSTN_I(rstn),
		.RX_VALID_I(rx_valid),
		.RX_BYTE_I(rx_byte),
		.CHECK_I(check),
		.STATE_I(st),
		.ROI_START_I(roi_s),
		.ROI_END_I(roi_e),
		.OUT_WRITE_FAIL_I(wfail),
		.UPD_EVT_I(upd),
		.MEAS_VALID_I(meas),
		.REPORT_VALID_O(rvalid),
		.REPORT_O(rep),
		.EXEC_O(exec),
		.MASTER_TAKE_O(take),
		.MASTER_BUSY_O(busy)
	);

	function automatic logic [13:0] err_n(input logic [`CODE_W-1:0] code);
		return {3'b010, code, 1'b0};
	endfunction

	function automatic logic [13:0] warn_n(input logic [`CODE_W-1:0] code);
		return {3'b111, code, 1'b0};
	endfunction

	function automatic cmd_check_s clean();
		cmd_check_s c;
		c = '0;
		{c.known, c.permitted, c.count_ok, c.type_ok} = 4'hF;
		{c.range_ok, c.master_ok, c.name_found, c.setting_ok} = 4'hF;
		return c;
	endfunction

	// Verdict held until the bench has let the last report drain
	task automatic line(input cmd_check_s c, input dev_state_s s,
		input int len, input int bad, input logic [13:0] e);
		@(posedge ref_clk);
		check <= c;
		st <= s;
		exp_q.push_back(e);
		i_host_model.send_line(len, bad);
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		logic [13:0] e;
		if ((exec | rvalid | take) === 1'b1)
		begin
			e = exp_q.size() ? exp_q.pop_front() : 14'h3FFF;
			`CHK({exec, rvalid, rvalid ? rep : 11'h000, take}, e);
		end
	end

	initial
	begin
		repeat (30000) @(posedge ref_clk);
		errors++;
		finish_test();
	end

	initial
	begin
		cmd_check_s c;
		dev_state_s s;
		logic [`CODE_W-1:0] w;
		int len;
		int bad;
		check = clean();
		st = IDLE;
		upd = '0;
		wfail = 1'b0;
		meas = 1'b0;
		rstn = 1'b0;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		line(clean(), IDLE, 0, -1, OK_N);
		line(clean(), IDLE, 255, -1, OK_N);
		$display("test clean lines done");
		for (int k = 0; k < 16; k++)
		begin
			c = clean();
			s = IDLE;
			len = 8;
			bad = -1;
			// Lowest fault always present, so every line but the last checks priority
			{c.is_load, c.setting_ok} = 2'b10;
			case (k)
				0: bad = 3;
				1: len = 256;
				2: c.known = 1'b0;
				3: c.permitted = 1'b0;
				4: c.needs_expert = 1'b1;
				5: c.count_ok = 1'b0;
				6: c.type_ok = 1'b0;
				7: c.range_ok = 1'b0;
				8: c.needs_stop = 1'b1;
				9: {c.is_master, c.master_ok} = 2'b10;
				10: c.is_swtrig = 1'b1;
				11:
				begin
					c.is_save = 1'b1;
					s.store_full = 1'b1;
				end
				12: {c.is_save, c.name_blank} = 2'b11;
				13: {c.is_save, c.name_bad} = 2'b11;
				14: c.name_found = 1'b0;
				default: ;
			endcase
			line(c, s, len, bad, err_n(codes[k]));
		end
		c = clean();
		{c.needs_stop, c.needs_expert} = 2'b11;
		line(c, 4'b1000, 5, -1, OK_N);
		$display("test error codes done");
		for (int k = 1; k < 4; k++)
		begin
			c = clean();
			{c.clipped, c.out_changed} = 2'(k);
			w = (k == 1) ? `W_OUT_ADAPTED : `W_CLIPPED;
			line(c, IDLE, 6, -1, warn_n(w));
		end
		$display("test warnings done");
		c = clean();
		c.is_roi = 1'b1;
		i_host_model.set_roi(9'h005, 9'h005);
		line(c, IDLE, 6, -1, OK_N);
		i_host_model.set_roi(9'h12C, 9'h0C8);
		line(c, IDLE, 6, -1, err_n(`E_ROI_ORDER));
		i_host_model.set_roi(9'h000, 9'h1FF);
		$display("test roi done");
		c = clean();
		c.is_master = 1'b1;
		line(c, IDLE, 6, -1, OK_N);
		#1;
		`CHK(busy, 1'b1);
		// Accepted line sends no report, so the region error still shows
		`CHK(rep, {1'b0, `E_ROI_ORDER});
		exp_q.push_back(14'h0001);
		@(posedge ref_clk);
		meas <= 1'b1;
		@(posedge ref_clk);
		meas <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(busy, 1'b0);
		line(c, IDLE, 6, -1, OK_N);
		exp_q.push_back(err_n(`E_MASTER_TMO));
		repeat (10) @(posedge ref_clk);
		#1;
		`CHK(busy, 1'b1);
		repeat (30) @(posedge ref_clk);
		`CHK(exp_q.size(), 0);
		$display("test mastering done");
		foreach (evc[i])
			exp_q.push_back(err_n(evc[i]));
		@(posedge ref_clk);
		wfail <= 1'b1;
		upd <= 4'hF;
		@(posedge ref_clk);
		wfail <= 1'b0;
		upd <= 4'h0;
		repeat (12) @(posedge ref_clk);
		`CHK(exp_q.size(), 0);
		$display("test events done");
		finish_test();
	end
endmodule

// ==== sim/host_model.sv ====
// Host side model: sends command lines byte by byte
`timescale 1ns/1ps
`include "cmd_report_defines.svh"

module host_model (
	input wire logic clk_i,
	output logic valid_o,
	output logic [7:0] byte_o,
	output logic [`ROI_W-1:0] roi_start_o,
	output logic [`ROI_W-1:0] roi_end_o
);
	integer seed = 32'h0D2561C1;

	initial
	begin
		valid_o = 1'b0;
		byte_o = 8'h00;
		roi_start_o = 9'h000;
		roi_end_o = 9'h1FF;
	end

	// Printable filler, one unsupported byte at bad_at if it is in range
	task automatic send_line(input int len, input int bad_at);
		for (int i = 0; i < len; i++)
		begin
			@(posedge clk_i);
			valid_o <= 1'b1;
			byte_o <= (i == bad_at) ? 8'h01
				: 8'h20 + 8'($unsigned($random(seed)) % 95);
		end
		@(posedge clk_i);
		valid_o <= 1'b1;
		byte_o <= `CH_CR;
		@(posedge clk_i);
		valid_o <= 1'b0;
		// Idle byte is not left at the last value
		byte_o <= ~byte_o;
	endtask

	task automatic set_roi(input logic [`ROI_W-1:0] s,
		input logic [`ROI_W-1:0] e);
		@(posedge clk_i);
		roi_start_o <= s;
		roi_end_o <= e;
	endtask
endmodule
